//--- rfc_flow_trigger.v
// Receive flow control trigger with its Avalon-MM register slave.
`timescale 1ns/100ps
`include "rfc_map.vh"

// Functional notes
// - Bits 7:4 of the configuration register hold a 4-bit jam duration code.
// - The jam duration code has no effect in full duplex.
// - At 100 Mb/s the codes give 5, 10, 15, 25 us, then 50 us steps up to 600 us.
// - At 10 Mb/s each code lasts 2.2 us longer than at 100 Mb/s.
// - Bit 3 jams a multicast frame once the fill level has reached the threshold.
// - Bit 2 jams a broadcast frame once the fill level has reached the threshold.
// - Bit 1 jams a frame for our own address once the threshold is reached.
// - Bits 3 to 1 do nothing in full duplex.
// - Bit 0 jams or pauses on any frame at or above threshold and enables full-duplex pausing.
// - In half duplex any-frame mode acts on the next preamble without address decoding.
// - In full duplex any-frame mode a pause is requested as soon as the threshold is hit.
// - Bit 0 overrides bits 3 to 1.
// - The threshold is compared with the fill level counted in 64-byte units.
// - In half duplex each matching frame is jammed for the coded duration.
// - Neither pause nor jam is produced while the transmitter is disabled.
module rfc_flow_trigger #(
   parameter CLK_MHZ = 25,
   parameter LVL_W = 14
) (
   input wire clock,
   input wire rst_n,
   input wire ce,
   input wire [`RFC_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire [LVL_W-1:0] rx_fifo_level,
   input wire rx_frame_start,
   input wire rx_addr_valid,
   input wire rx_is_multicast,
   input wire rx_is_broadcast,
   input wire rx_addr_match,
   input wire full_duplex,
   input wire speed_100,
   input wire tx_enable,
   output reg jam_active,
   output reg pause_req
);

   // -------------------------------------------------------------------------
   // Address decoding
   // -------------------------------------------------------------------------
   function hit;
      input [`RFC_ADDR_W-1:0] addr;
      input [`RFC_ADDR_W-1:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   localparam LVL_UNITS_W = LVL_W - `RFC_UNIT_SHIFT;

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   reg [31:0] flow_control_config_r;
   reg [31:0] cfg_nxt;
   reg [15:0] jam_count_r;
   reg [15:0] pause_count_r;
   reg hi_reached_r;
   reg paused_r;
   reg [31:0] rdata_nxt;

   wire access;
   wire wr_en;
   wire cfg_wr;
   wire cnt_wr;
   wire [LVL_UNITS_W-1:0] lvl_units;
   wire [7:0] fifo_high_threshold;
   wire [3:0] jam_duration_code;
   wire [3:0] trig_cfg;
   wire hi_now;
   wire jam_start;
   wire pause_cond;
   wire pause_fire;
   wire timer_active;
   wire timer_stop;
   wire [31:0] wmask;
   wire [31:0] status_word;

   // -------------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------------
   // The request is held until the cycle in which waitrequest is low, so a
   // write lands exactly once, on the edge that completes the transfer.
   assign access = (avs_read || avs_write) && avs_waitrequest;
   assign wr_en = avs_write && !avs_waitrequest;
   assign cfg_wr = wr_en && hit(avs_address, `RFC_CFG_ADDR);
   assign cnt_wr = wr_en && hit(avs_address, `RFC_CNT_ADDR);

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else if (ce) begin
         avs_waitrequest <= !access;
      end
   end

   // -------------------------------------------------------------------------
   // Byte lane mask
   // -------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign wmask[gi*8+7:gi*8] = {8{avs_byteenable[gi]}};
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Configuration register
   // -------------------------------------------------------------------------
   always @* begin
      cfg_nxt = flow_control_config_r;
      if (cfg_wr) begin
         cfg_nxt = ((avs_writedata & wmask) | (flow_control_config_r & ~wmask))
            & `RFC_CFG_WMASK;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flow_control_config_r <= `RFC_CFG_RST;
      end else if (ce) begin
         flow_control_config_r <= cfg_nxt;
      end
   end

   assign fifo_high_threshold = flow_control_config_r[`RFC_HI_MSB:`RFC_HI_LSB];
   assign jam_duration_code = flow_control_config_r[`RFC_DUR_MSB:`RFC_DUR_LSB];
   assign trig_cfg = flow_control_config_r[`RFC_BIT_MULT:`RFC_BIT_ANY];

   // -------------------------------------------------------------------------
   // Threshold compare
   // -------------------------------------------------------------------------
   // Comparing whole 64-byte units avoids a wide multiply of the threshold.
   assign lvl_units = rx_fifo_level[LVL_W-1:`RFC_UNIT_SHIFT];
   assign hi_now = ({8'h00, lvl_units} >= {{LVL_UNITS_W{1'b0}}, fifo_high_threshold});

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hi_reached_r <= 1'b0;
      end else if (ce) begin
         hi_reached_r <= hi_now;
      end
   end

   // -------------------------------------------------------------------------
   // Trigger selection
   // -------------------------------------------------------------------------
   rfc_trig_sel u_sel (
      .trig_cfg(trig_cfg),
      .full_duplex(full_duplex),
      .tx_enable(tx_enable),
      .hi_reached(hi_reached_r),
      .rx_frame_start(rx_frame_start),
      .rx_addr_valid(rx_addr_valid),
      .rx_is_multicast(rx_is_multicast),
      .rx_is_broadcast(rx_is_broadcast),
      .rx_addr_match(rx_addr_match),
      .jam_start(jam_start),
      .pause_cond(pause_cond)
   );

   // -------------------------------------------------------------------------
   // Jam timer
   // -------------------------------------------------------------------------
   // Going full duplex or losing the transmitter ends a jam at once.
   assign timer_stop = full_duplex || !tx_enable;

   rfc_jam_timer #(
      .CLK_MHZ(CLK_MHZ)
   ) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .start(jam_start),
      .stop(timer_stop),
      .code(jam_duration_code),
      .speed_100(speed_100),
      .active(timer_active)
   );

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         jam_active <= 1'b0;
      end else if (ce) begin
         jam_active <= timer_active && !timer_stop;
      end
   end

   // -------------------------------------------------------------------------
   // Pause request
   // -------------------------------------------------------------------------
   // Only one pause is asked for per crossing; the arm resets once the level
   // falls below the threshold again. Queuing is the transmitter's job.
   assign pause_fire = pause_cond && !paused_r;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         paused_r <= 1'b0;
         pause_req <= 1'b0;
      end else if (ce) begin
         pause_req <= pause_fire;
         if (pause_fire) begin
            paused_r <= 1'b1;
         end else if (!hi_reached_r) begin
            paused_r <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Event counters
   // -------------------------------------------------------------------------
   // A write clears both counters, but an event in the same cycle still counts.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         jam_count_r <= 16'h0000;
         pause_count_r <= 16'h0000;
      end else if (ce) begin
         if (jam_start) begin
            jam_count_r <= cnt_wr ? 16'h0001 :
               ((jam_count_r == 16'hFFFF) ? jam_count_r : jam_count_r + 16'h0001);
         end else if (cnt_wr) begin
            jam_count_r <= 16'h0000;
         end
         if (pause_fire) begin
            pause_count_r <= cnt_wr ? 16'h0001 :
               ((pause_count_r == 16'hFFFF) ? pause_count_r : pause_count_r + 16'h0001);
         end else if (cnt_wr) begin
            pause_count_r <= 16'h0000;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Status word
   // -------------------------------------------------------------------------
   assign status_word = {{(16 - LVL_UNITS_W){1'b0}}, lvl_units, 10'h000,
      tx_enable, speed_100, full_duplex, paused_r, jam_active, hi_reached_r};

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   always @* begin
      rdata_nxt = 32'h00000000;
      if (hit(avs_address, `RFC_CFG_ADDR)) begin
         rdata_nxt = flow_control_config_r;
      end else if (hit(avs_address, `RFC_STAT_ADDR)) begin
         rdata_nxt = status_word;
      end else if (hit(avs_address, `RFC_CNT_ADDR)) begin
         rdata_nxt = {pause_count_r, jam_count_r};
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (ce) begin
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rdata_nxt;
         end
      end
   end

endmodule // rfc_flow_trigger

//--- rfc_map.vh
// Register map, field positions and timing constants of the flow control trigger.
`ifndef RFC_MAP_VH
`define RFC_MAP_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define RFC_ADDR_W 8
`define RFC_CFG_ADDR 8'hAC
`define RFC_STAT_ADDR 8'hC0
`define RFC_CNT_ADDR 8'hC4

// ----------------------------------------------------------------------------
// Configuration register layout
// ----------------------------------------------------------------------------
`define RFC_CFG_RST 32'h00000000
`define RFC_CFG_WMASK 32'h00FFFFFF
`define RFC_HI_MSB 23
`define RFC_HI_LSB 16
`define RFC_DUR_MSB 7
`define RFC_DUR_LSB 4
`define RFC_BIT_MULT 3
`define RFC_BIT_BRD 2
`define RFC_BIT_ADD 1
`define RFC_BIT_ANY 0

// ----------------------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------------------
`define RFC_ST_HI 0
`define RFC_ST_JAM 1
`define RFC_ST_PAUSED 2
`define RFC_ST_FD 3
`define RFC_ST_SPD 4
`define RFC_ST_TXEN 5
`define RFC_ST_LVL_LSB 16

// ----------------------------------------------------------------------------
// Fill level unit and jam timing, in 200 ns ticks
// ----------------------------------------------------------------------------
`define RFC_UNIT_SHIFT 6
`define RFC_TICK_NS 200
`define RFC_DUR_C0 12'h019
`define RFC_DUR_C1 12'h032
`define RFC_DUR_C2 12'h04B
`define RFC_DUR_C3 12'h07D
`define RFC_DUR_STEP 12'h0FA
`define RFC_DUR_BASE 12'h003
`define RFC_DUR_10M_EXTRA 12'h00B

`endif

//--- rfc_jam_timer.v
// Jam duration timer driven by a 200 ns tick prescaler.
`timescale 1ns/100ps
`include "rfc_map.vh"

module rfc_jam_timer #(
   parameter CLK_MHZ = 25
) (
   input wire clock,
   input wire rst_n,
   input wire ce,
   input wire start,
   input wire stop,
   input wire [3:0] code,
   input wire speed_100,
   output reg active
);

   // -------------------------------------------------------------------------
   // Tick prescaler
   // -------------------------------------------------------------------------
   localparam integer TICK_CYCLES = (`RFC_TICK_NS * CLK_MHZ + 999) / 1000;
   localparam integer TICK_LAST = TICK_CYCLES - 1;

   reg [7:0] pre_r;
   reg [11:0] cnt_r;
   wire tick;

   assign tick = ({24'h000000, pre_r} == TICK_LAST);

   // The 10 Mb/s figures are the 100 Mb/s figures plus 2.2 us.
   function [11:0] dur_ticks;
      input [3:0] c;
      input fast;
      reg [11:0] base;
      begin
         case (c)
            4'h0: base = `RFC_DUR_C0;
            4'h1: base = `RFC_DUR_C1;
            4'h2: base = `RFC_DUR_C2;
            4'h3: base = `RFC_DUR_C3;
            default: base = ({8'h00, c} - `RFC_DUR_BASE) * `RFC_DUR_STEP;
         endcase
         dur_ticks = fast ? base : base + `RFC_DUR_10M_EXTRA;
      end
   endfunction

   // -------------------------------------------------------------------------
   // Countdown
   // -------------------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 8'h00;
         cnt_r <= 12'h000;
         active <= 1'b0;
      end else if (ce) begin
         if (stop) begin
            active <= 1'b0;
            pre_r <= 8'h00;
         end else if (start) begin
            cnt_r <= dur_ticks(code, speed_100);
            pre_r <= 8'h00;
            active <= 1'b1;
         end else if (active) begin
            pre_r <= tick ? 8'h00 : pre_r + 8'h01;
            if (tick) begin
               cnt_r <= cnt_r - 12'h001;
               if (cnt_r == 12'h001) begin
                  active <= 1'b0;
               end
            end
         end
      end
   end

endmodule // rfc_jam_timer

//--- rfc_trig_sel.v
// Selection of frames and conditions that start jamming or a pause request.
`timescale 1ns/100ps
`include "rfc_map.vh"

module rfc_trig_sel (
   input wire [3:0] trig_cfg,
   input wire full_duplex,
   input wire tx_enable,
   input wire hi_reached,
   input wire rx_frame_start,
   input wire rx_addr_valid,
   input wire rx_is_multicast,
   input wire rx_is_broadcast,
   input wire rx_addr_match,
   output wire jam_start,
   output wire pause_cond
);

   wire any_sel;
   wire hd_ok;
   wire class_hit;

   assign any_sel = trig_cfg[`RFC_BIT_ANY];
   // No jam is raised in full duplex or with the transmitter off.
   assign hd_ok = !full_duplex && tx_enable && hi_reached;
   assign class_hit = (trig_cfg[`RFC_BIT_MULT] && rx_is_multicast) ||
      (trig_cfg[`RFC_BIT_BRD] && rx_is_broadcast) ||
      (trig_cfg[`RFC_BIT_ADD] && rx_addr_match);

   // Any-frame acts on the preamble and bypasses the address classes.
   assign jam_start = hd_ok && (any_sel ? rx_frame_start :
      (rx_addr_valid && class_hit));
   assign pause_cond = full_duplex && tx_enable && hi_reached && any_sel;

endmodule // rfc_trig_sel

//--- rfc_flow_trigger_asserts.sv
// Port-level concurrent checks for the flow control trigger.
`timescale 1ns/100ps
module rfc_flow_trigger_asserts (
   input wire clock,
   input wire rst_n,
   input wire ce,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire rx_frame_start,
   input wire rx_addr_valid,
   input wire full_duplex,
   input wire tx_enable,
   input wire jam_active,
   input wire pause_req
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_wait_ans;
      ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("bus request not answered in one cycle");
   property p_wait_one;
      ce && !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_fd_jam;
      ce && full_duplex |=> !jam_active;
   endproperty
   a_fd_jam: assert property (p_fd_jam) else $error("jam in full duplex");
   property p_tx_off;
      ce && !tx_enable |=> !jam_active && !pause_req;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("flow control with transmitter off");
   property p_pause_one;
      ce && pause_req |=> !pause_req;
   endproperty
   a_pause_one: assert property (p_pause_one) else $error("pause request not a pulse");
   property p_pause_fd;
      pause_req |-> $past(full_duplex && tx_enable);
   endproperty
   a_pause_fd: assert property (p_pause_fd) else $error("pause outside full duplex");
   property p_jam_cause;
      $rose(jam_active) |-> $past(rx_frame_start || rx_addr_valid, 2)
         || $past(rx_frame_start || rx_addr_valid, 3);
   endproperty
   a_jam_cause: assert property (p_jam_cause) else $error("jam without a frame");
   // The shortest code is far above seven cycles, so an early drop means a broken count.
   property p_jam_hold;
      $rose(jam_active) |=> (jam_active || $past(full_duplex) || !$past(tx_enable))[*7];
   endproperty
   a_jam_hold: assert property (p_jam_hold) else $error("jam ended too early");
endmodule // rfc_flow_trigger_asserts

bind rfc_flow_trigger rfc_flow_trigger_asserts chk_u (.clock(clock), .rst_n(rst_n), .ce(ce),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .rx_frame_start(rx_frame_start), .rx_addr_valid(rx_addr_valid), .full_duplex(full_duplex),
   .tx_enable(tx_enable), .jam_active(jam_active), .pause_req(pause_req));

//--- rfc_far_model.sv
// Far-side model: frame filter events and a counter of pause requests.
`timescale 1ns/100ps
module rfc_far_model (
   input wire clock,
   input wire pause_req,
   output reg rx_frame_start,
   output reg rx_addr_valid,
   output reg rx_is_multicast,
   output reg rx_is_broadcast,
   output reg rx_addr_match,
   output reg [7:0] pause_seen
);
   initial begin
      {rx_frame_start, rx_addr_valid, rx_is_multicast, rx_is_broadcast, rx_addr_match} = 5'h00;
      pause_seen = 8'h00;
   end
   always @(posedge clock) begin
      if (pause_req === 1'b1) pause_seen <= pause_seen + 8'h01;
   end
   // Unqualified class lines show the opposite value, so a stale match cannot pass.
   task frame(input logic mc, input logic bc, input logic am);
      begin
         rx_frame_start <= 1'b1;
         @(posedge clock);
         rx_frame_start <= 1'b0;
         rx_addr_valid <= 1'b1;
         {rx_is_multicast, rx_is_broadcast, rx_addr_match} <= {mc, bc, am};
         @(posedge clock);
         rx_addr_valid <= 1'b0;
         {rx_is_multicast, rx_is_broadcast, rx_addr_match} <= ~{mc, bc, am};
      end
   endtask
endmodule // rfc_far_model

//--- rfc_flow_trigger_bench.sv
// Self-checking bench for the flow control trigger.
`timescale 1ns/100ps
`include "rfc_map.vh"
module rfc_flow_trigger_bench;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [13:0] rx_fifo_level = 14'h0000;
   logic full_duplex = 1'b0;
   logic speed_100 = 1'b1;
   logic tx_enable = 1'b1;
   logic ce = 1'b1;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, jam_active, pause_req, rx_frame_start, rx_addr_valid;
   wire rx_is_multicast, rx_is_broadcast, rx_addr_match;
   wire [7:0] pause_seen;
   integer fail_count = 0;
   integer checks_done = 0;
   integer i, n;
   logic [31:0] q;
   logic [7:0] base;
   // Row: trigger bits, full duplex, multicast, broadcast, own address, jam expected.
   logic [8:0] rows [0:9] = '{9'b0001_0_000_1, 9'b1000_0_100_1, 9'b1000_0_010_0,
      9'b0100_0_010_1, 9'b0010_0_001_1, 9'b0010_0_110_0, 9'b1110_1_111_0,
      9'b0001_1_000_0, 9'b0000_0_111_0, 9'b1111_0_000_1};

   // A 1-cycle jam tick keeps the longest code near three thousand cycles.
   rfc_flow_trigger #(.CLK_MHZ(5), .LVL_W(14)) dut_u (.clock(clock), .rst_n(rst_n), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_fifo_level(rx_fifo_level), .rx_frame_start(rx_frame_start),
      .rx_addr_valid(rx_addr_valid), .rx_is_multicast(rx_is_multicast),
      .rx_is_broadcast(rx_is_broadcast), .rx_addr_match(rx_addr_match),
      .full_duplex(full_duplex), .speed_100(speed_100), .tx_enable(tx_enable),
      .jam_active(jam_active), .pause_req(pause_req));
   rfc_far_model far_u (.clock(clock), .pause_req(pause_req), .rx_frame_start(rx_frame_start),
      .rx_addr_valid(rx_addr_valid), .rx_is_multicast(rx_is_multicast),
      .rx_is_broadcast(rx_is_broadcast), .rx_addr_match(rx_addr_match),
      .pause_seen(pause_seen));

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   initial begin
      forever #20 clock = ~clock;
   end
   task chk(input logic ok, input string msg);
      begin
         checks_done = checks_done + 1;
         if (ok !== 1'b1) begin
            fail_count = fail_count + 1;
            $display("ERROR %0t %s", $time, msg);
         end
      end
   endtask
   task print_verdict;
      begin
         if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      begin
         n = 0;
         @(posedge clock);
         avs_read <= ~wr;
         avs_write <= wr;
         avs_address <= a;
         avs_writedata <= d;
         avs_byteenable <= be;
         @(posedge clock);
         while (avs_waitrequest !== 1'b0 && n < 20) begin
            n = n + 1;
            @(posedge clock);
         end
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         chk(n < 20, "bus answer missing");
      end
   endtask
   task cfg(input logic [31:0] d);
      xfer(1'b1, `RFC_CFG_ADDR, d, 4'hF);
   endtask
   // Sends one frame and leaves the number of jam cycles in n.
   task measure(input logic mc, input logic bc, input logic am);
      begin
         @(posedge clock);
         far_u.frame(mc, bc, am);
         n = 0;
         while (jam_active !== 1'b1 && n < 8) begin
            n = n + 1;
            @(posedge clock);
         end
         n = 0;
         while (jam_active === 1'b1 && n < 4000) begin
            n = n + 1;
            @(posedge clock);
         end
      end
   endtask
   function integer ticks(input integer c, input logic fast);
      ticks = (c < 4 ? (c == 3 ? 125 : 25 * (c + 1)) : 250 * (c - 3)) + (fast ? 0 : 11);
   endfunction
   task pause_try(input logic [31:0] d, input integer add);
      begin
         rx_fifo_level <= 14'd0;
         cfg(d);
         base = pause_seen;
         rx_fifo_level <= 14'd128;
         repeat (20) @(posedge clock);
         chk(pause_seen === base + add, "pause count");
      end
   endtask

   // ----------------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      chk(jam_active === 1'b0 && pause_req === 1'b0, "outputs after reset");
      xfer(1'b0, `RFC_CFG_ADDR, 32'h00000000, 4'hF);
      chk(q === 32'h00000000, "config reset value");
      xfer(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF);
      xfer(1'b0, 8'h10, 32'h00000000, 4'hF);
      chk(q === 32'h00000000, "unmapped read");
      cfg(32'hFFFFFFFF);
      xfer(1'b0, `RFC_CFG_ADDR, 32'h00000000, 4'hF);
      chk(q === 32'h00FFFFFF, "config readback");
      xfer(1'b1, `RFC_CFG_ADDR, 32'h00000000, 4'h1);
      xfer(1'b0, `RFC_CFG_ADDR, 32'h00000000, 4'hF);
      chk(q === 32'h00FFFF00, "byte lane write");
      rx_fifo_level <= 14'd63;
      cfg(32'h00010001);
      measure(1'b0, 1'b0, 1'b0);
      chk(n === 0, "jam below threshold");
      rx_fifo_level <= 14'd64;
      measure(1'b0, 1'b0, 1'b0);
      chk(n === ticks(0, 1'b1), "jam at threshold");
      for (i = 0; i < 10; i = i + 1) begin
         full_duplex <= rows[i][4];
         cfg({24'h000100, 4'h0, rows[i][8:5]});
         measure(rows[i][3], rows[i][2], rows[i][1]);
         chk((n > 0) === rows[i][0], "frame selection");
      end
      full_duplex <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
         speed_100 <= ~i[4];
         cfg({24'h000100, i[3:0], 4'h1});
         measure(1'b0, 1'b0, 1'b0);
         chk(n === ticks(i % 16, ~i[4]), "jam length");
      end
      @(posedge clock);
      far_u.frame(1'b0, 1'b0, 1'b0);
      repeat (10) @(posedge clock);
      chk(jam_active === 1'b1, "long jam running");
      ce <= 1'b0;
      full_duplex <= 1'b1;
      repeat (4) @(posedge clock);
      chk(jam_active === 1'b1, "jam not frozen by clock enable");
      ce <= 1'b1;
      repeat (2) @(posedge clock);
      chk(jam_active === 1'b0, "jam kept in full duplex");
      pause_try(32'h00020001, 1);
      pause_try(32'h00020001, 1);
      pause_try(32'h0002000E, 0);
      tx_enable <= 1'b0;
      pause_try(32'h00020001, 0);
      full_duplex <= 1'b0;
      measure(1'b0, 1'b0, 1'b0);
      chk(n === 0, "jam with transmitter off");
      // Thirty-nine jam starts and three pause requests have happened by now.
      xfer(1'b0, `RFC_CNT_ADDR, 32'h00000000, 4'hF);
      chk(q === 32'h00030027, "event counters");
      xfer(1'b0, `RFC_STAT_ADDR, 32'h00000000, 4'hF);
      chk(q === 32'h00020001, "status word");
      xfer(1'b1, `RFC_CNT_ADDR, 32'h00000000, 4'hF);
      xfer(1'b0, `RFC_CNT_ADDR, 32'h00000000, 4'hF);
      chk(q === 32'h00000000, "counter clear");
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      xfer(1'b0, `RFC_CFG_ADDR, 32'h00000000, 4'hF);
      chk(q === 32'h00000000, "config after second reset");
      print_verdict;
   end
   initial begin
      #(40 * 80000);
      fail_count = fail_count + 1;
      print_verdict;
   end
endmodule // rfc_flow_trigger_bench
